// [lic_pkg.sv]
/*
  Constants, opcodes and types shared by the LCD instruction core.
  Assumes the core clock is the display oscillator and runs at 50 MHz.
*/
package lic_pkg;
  // Wishbone byte offsets
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_DATA = 8'h04;
  localparam logic [7:0] ADR_CFG = 8'h08;
  // Execution times in oscillator cycles
  localparam logic [7:0] EXEC_CYC = 8'h03;
  localparam logic [7:0] CLEAR_CYC = 8'hA5;
  localparam int BLINK_DIV = 52224;
  // Text address layout
  localparam logic [6:0] LINE2_BASE = 7'h40;
  localparam logic [6:0] LAST_L1 = 7'h27;
  localparam logic [6:0] LAST_L2 = 7'h67;
  localparam logic [6:0] LAST_1L = 7'h4F;
  localparam logic [5:0] SHIFT_LAST = 6'h27;
  localparam logic [7:0] BLANK_CODE = 8'h20;
  localparam int TEXT_DEPTH = 128;
  localparam int GLYPH_DEPTH = 128;
  localparam int GLYPH_W = 5;
  localparam logic [6:0] ICON_ODD_BASE = 7'h20;
  // Opcode prefixes, compared against the upper bits of the byte
  localparam logic [7:0] OPC_CLEAR = 8'h01;
  localparam logic [6:0] OPC_HOME = 7'h01;
  localparam logic [5:0] OPC_ENTRY = 6'h01;
  localparam logic [4:0] OPC_DCTL = 5'h01;
  localparam logic [3:0] OPC_SHIFT = 4'h1;
  localparam logic [2:0] OPC_FUNC = 3'h1;
  localparam logic [1:0] OPC_SGLYPH = 2'h1;
  localparam logic [6:0] OPC_SCREEN = 7'h01;
  localparam logic [5:0] OPC_DCFG = 6'h01;
  localparam logic [4:0] OPC_ICON = 5'h01;
  // Reset values
  localparam logic RST_BUS_WIDTH = 1'b1;
  localparam logic RST_INCR = 1'b1;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CLEAR} lic_state_t;
endpackage

// [lic_core.sv]
/*
  Instruction execution core of a character and icon LCD controller:
  4/8-bit parallel host port, Wishbone register port, text and glyph memory,
  cursor and icon blink, shift, mirroring and icon mode settings.
  Assumes all inputs synchronous to clk_i (the oscillator) and a host that
  holds db_i, rs_i and rw_i stable while e_i is high.
*/
// Added by the designer: the address map and the Wishbone interface to the registers.
// Behaviour
// - cursor_show draws a five-dot underline on row eight; stepping continues when hidden
// - cursor_char_blink alternates cell and all-lit at oscillator over 52224
// - shift moves cursor or display only; cursor wraps after 40 in two-line mode, 80 in one-line; no cross-line shift
// - display shift keeps addr_counter; cursor shift steps it by direction
// - bus_width_sel 1 moves whole bytes; 0 moves two nibbles on upper lines
// - floating low lines set two_line and ext in first function set; host repeats it
// - function set from the serial path forces bus_width_sel to 1
// - two_line_sel 0 gives one line of 24, 1 gives two of 12
// - ext_set_sel picks basic or extended instruction decoding
// - set glyph address loads addr_counter bits 5..0, keeps bit 6
// - set text/glyph address loads counter and selects the memory for data
// - busy read returns busy_flag and counter; instructions arriving while busy are dropped
// - data write stores to selected memory then steps; glyph keeps five bits
// - data read drives read_latch while strobe high, then steps and reloads
// - only set-address and data read update read_latch
// - icon_only_sel picks full 1:18 or icon-only 1:2 drive
// - icons come from glyph chars 0-2, odd blink phase from 4-6
// - icon blink shares cursor phases: even underline and block, odd normal
// - half_mirror_sel resets to 0; 1 mirrors split-screen column pairing in one-line mode only (half_mirror_o is 0 while two_line_sel is 1)
// - column_mirror and row_mirror reset to 0 and reverse data order
// - 4-bit transfers, busy read included, send high nibble then low
// - display control is 00001 plus three flags, three cycles
// - function set is 001,width,0,lines,0,ext in both sets, three cycles
// - icon control is 00001,icon_only,icon_blink,0 in extended set, three cycles
`timescale 1ns/1ps
module lic_core
  import lic_pkg::*;
#(
  parameter int BLINK_HALF = BLINK_DIV / 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic e_i,
  input wire logic reg_select_i,
  input wire logic rw_i,
  input wire logic [7:0] db_i,
  output logic [7:0] db_o,
  output logic db_oe_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [4:0] icon_idx_i,
  output logic [4:0] icon_row_o,
  output logic display_on_o,
  output logic cursor_underline_o,
  output logic cursor_block_o,
  output logic [6:0] cursor_addr_o,
  output logic [5:0] disp_shift_o,
  output logic two_line_o,
  output logic icon_only_o,
  output logic half_mirror_o,
  output logic column_mirror_o,
  output logic row_mirror_o
);
  logic [7:0] text_memory [TEXT_DEPTH];
  logic [GLYPH_W-1:0] glyph_memory [GLYPH_DEPTH];
  logic [6:0] addr_counter;
  logic [6:0] next_ac;
  logic [7:0] read_latch;
  logic sel_glyph;
  logic next_sel_glyph;
  logic bus_width_sel, two_line_sel, ext_set_sel, incr, entry_shift;
  logic display_on, cursor_show, cursor_char_blink;
  logic icon_only_sel, icon_blink_en, half_mirror_sel, column_mirror, row_mirror;
  logic [5:0] disp_shift;
  lic_state_t st;
  logic [7:0] busy_cnt;
  logic [6:0] clr_idx;
  logic busy_flag;
  logic [15:0] blink_cnt;
  logic odd_phase;

  // Parallel front end: transfer taken on the falling strobe
  logic e_q, cap_rs, cap_rw, nib;
  logic [7:0] cap_db;
  logic [3:0] hi_nib;
  logic e_fall, par_done;
  logic [7:0] par_byte;
  assign e_fall = e_q & ~e_i;
  assign par_done = e_fall & (bus_width_sel | nib);
  assign par_byte = bus_width_sel ? cap_db : {hi_nib, cap_db[7:4]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      e_q <= 1'b0;
      cap_db <= 8'h00;
      cap_rs <= 1'b0;
      cap_rw <= 1'b0;
    end else begin
      e_q <= e_i;
      if (e_i) begin
        cap_db <= db_i;
        cap_rs <= reg_select_i;
        cap_rw <= rw_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nib <= 1'b0;
      hi_nib <= 4'h0;
    end else if (bus_width_sel) begin
      nib <= 1'b0;
    end else if (e_fall) begin
      nib <= ~nib;
      if (!nib) begin
        hi_nib <= cap_db[7:4];
      end
    end
  end

  // Request selection; the parallel port wins and Wishbone waits a cycle
  logic wb_req, wb_exec, req, req_rs, req_rw, req_serial, go;
  logic [7:0] b;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_exec = wb_req & wb_we_i & wb_sel_i[0] & ~par_done & ((wb_adr_i == ADR_CMD) | (wb_adr_i == ADR_DATA));

  always_comb begin
    if (par_done) begin
      req = 1'b1;
      req_rs = cap_rs;
      req_rw = cap_rw;
      req_serial = 1'b0;
      b = par_byte;
    end else begin
      req = wb_exec;
      req_rs = (wb_adr_i == ADR_DATA);
      req_rw = 1'b0;
      req_serial = 1'b1;
      b = wb_dat_i[7:0];
    end
  end

  // Busy read is not an instruction; anything else is dropped while busy_flag is set
  assign go = req & ~busy_flag & (~req_rw | req_rs);

  logic is_write, is_read, ins, basic, ext;
  logic i_clear, i_home, i_entry, i_dctl, i_shift, i_func, i_sglyph, i_stext;
  logic x_screen, x_dcfg, x_icon;
  assign is_write = go & req_rs & ~req_rw;
  assign is_read = go & req_rs & req_rw;
  assign ins = go & ~req_rs & ~req_rw;
  assign basic = ins & ~ext_set_sel;
  assign ext = ins & ext_set_sel;
  assign i_clear = basic & (b == OPC_CLEAR);
  assign i_home = basic & (b[7:1] == OPC_HOME);
  assign i_entry = basic & (b[7:2] == OPC_ENTRY);
  assign i_dctl = basic & (b[7:3] == OPC_DCTL);
  assign i_shift = basic & (b[7:4] == OPC_SHIFT);
  assign i_func = ins & (b[7:5] == OPC_FUNC);
  assign i_sglyph = basic & (b[7:6] == OPC_SGLYPH);
  assign i_stext = basic & b[7];
  assign x_screen = ext & (b[7:1] == OPC_SCREEN);
  assign x_dcfg = ext & (b[7:2] == OPC_DCFG);
  assign x_icon = ext & (b[7:3] == OPC_ICON) & ~b[0];

  // Text cursor stepping with line wrap after position 40 in two-line mode
  function automatic logic [6:0] text_step(input logic [6:0] a, input logic up, input logic two);
    logic [6:0] r;
    r = a;
    if (two) begin
      if (up) begin
        r = (a == LAST_L1) ? LINE2_BASE : (a == LAST_L2) ? 7'h00 : a + 7'h01;
      end else begin
        r = (a == 7'h00) ? LAST_L2 : (a == LINE2_BASE) ? LAST_L1 : a - 7'h01;
      end
    end else begin
      if (up) begin
        r = (a == LAST_1L) ? 7'h00 : a + 7'h01;
      end else begin
        r = (a == 7'h00) ? LAST_1L : a - 7'h01;
      end
    end
    return r;
  endfunction

  function automatic logic [5:0] shift_step(input logic [5:0] s, input logic right);
    logic [5:0] r;
    r = s;
    if (right) begin
      r = (s == SHIFT_LAST) ? 6'h00 : s + 6'h01;
    end else begin
      r = (s == 6'h00) ? SHIFT_LAST : s - 6'h01;
    end
    return r;
  endfunction

  always_comb begin
    next_ac = addr_counter;
    next_sel_glyph = sel_glyph;
    if (i_clear || i_home) begin
      next_ac = 7'h00;
      next_sel_glyph = 1'b0;
    end else if (i_stext) begin
      next_ac = b[6:0];
      next_sel_glyph = 1'b0;
    end else if (i_sglyph) begin
      next_ac = {addr_counter[6], b[5:0]};
      next_sel_glyph = 1'b1;
    end else if (i_shift && !b[3]) begin
      next_ac = text_step(addr_counter, b[2], two_line_sel);
    end else if (is_write || is_read) begin
      if (sel_glyph) begin
        next_ac = incr ? addr_counter + 7'h01 : addr_counter - 7'h01;
      end else begin
        next_ac = text_step(addr_counter, incr, two_line_sel);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_counter <= 7'h00;
      sel_glyph <= 1'b0;
    end else begin
      addr_counter <= next_ac;
      sel_glyph <= next_sel_glyph;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_latch <= 8'h00;
    end else if (i_stext || i_sglyph || is_read) begin
      // Prefetch at the new address so the next read finds it ready
      read_latch <= next_sel_glyph ? {3'b000, glyph_memory[next_ac]} : text_memory[next_ac];
    end
  end

  always_ff @(posedge clk_i) begin
    if (st == ST_CLEAR) begin
      text_memory[clr_idx] <= BLANK_CODE;
    end else if (is_write && !sel_glyph) begin
      text_memory[addr_counter] <= b;
    end
  end

  always_ff @(posedge clk_i) begin
    if (is_write && sel_glyph) begin
      glyph_memory[addr_counter] <= b[GLYPH_W-1:0];
    end
  end

  // Mode and configuration bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_width_sel <= RST_BUS_WIDTH;
      two_line_sel <= 1'b0;
      ext_set_sel <= 1'b0;
      incr <= RST_INCR;
      entry_shift <= 1'b0;
      display_on <= 1'b0;
      cursor_show <= 1'b0;
      cursor_char_blink <= 1'b0;
      icon_only_sel <= 1'b0;
      icon_blink_en <= 1'b0;
      half_mirror_sel <= 1'b0;
      column_mirror <= 1'b0;
      row_mirror <= 1'b0;
    end else begin
      if (i_func) begin
        // Floating low lines arrive here as ones in a 4-bit start-up
        bus_width_sel <= req_serial | b[4];
        two_line_sel <= b[2];
        ext_set_sel <= b[0];
      end
      if (i_clear) begin
        incr <= 1'b1;
      end
      if (i_entry) begin
        incr <= b[1];
        entry_shift <= b[0];
      end
      if (i_dctl) begin
        display_on <= b[2];
        cursor_show <= b[1];
        cursor_char_blink <= b[0];
      end
      if (x_icon) begin
        icon_only_sel <= b[2];
        icon_blink_en <= b[1];
      end
      if (x_screen) begin
        half_mirror_sel <= b[0];
      end
      if (x_dcfg) begin
        column_mirror <= b[1];
        row_mirror <= b[0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disp_shift <= 6'h00;
    end else if (i_clear || i_home) begin
      disp_shift <= 6'h00;
    end else if (i_shift && b[3]) begin
      disp_shift <= shift_step(disp_shift, b[2]);
    end else if (is_write && !sel_glyph && entry_shift) begin
      disp_shift <= shift_step(disp_shift, ~incr);
    end
  end

  // Execution timer
  assign busy_flag = (st != ST_IDLE);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ST_IDLE;
      busy_cnt <= 8'h00;
      clr_idx <= 7'h00;
    end else begin
      case (st)
        ST_IDLE: begin
          clr_idx <= 7'h00;
          if (go) begin
            st <= i_clear ? ST_CLEAR : ST_WAIT;
            busy_cnt <= i_clear ? CLEAR_CYC : EXEC_CYC;
          end
        end
        ST_WAIT, ST_CLEAR: begin
          clr_idx <= clr_idx + 7'h01;
          busy_cnt <= busy_cnt - 8'h01;
          if (busy_cnt == 8'h01) begin
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Blink phase: one full period is BLINK_DIV oscillator cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt <= 16'h0000;
      odd_phase <= 1'b0;
    end else if (blink_cnt == 16'(BLINK_HALF - 1)) begin
      blink_cnt <= 16'h0000;
      odd_phase <= ~odd_phase;
    end else begin
      blink_cnt <= blink_cnt + 16'h0001;
    end
  end

  // Display-side outputs; the cursor is hidden while glyph memory is the target
  logic [6:0] icon_addr;
  assign icon_addr = (icon_blink_en & odd_phase) ? (ICON_ODD_BASE | {2'b00, icon_idx_i}) : {2'b00, icon_idx_i};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      icon_row_o <= '0;
      display_on_o <= 1'b0;
      cursor_underline_o <= 1'b0;
      cursor_block_o <= 1'b0;
      cursor_addr_o <= 7'h00;
      disp_shift_o <= 6'h00;
      two_line_o <= 1'b0;
      icon_only_o <= 1'b0;
      half_mirror_o <= 1'b0;
      column_mirror_o <= 1'b0;
      row_mirror_o <= 1'b0;
    end else begin
      icon_row_o <= glyph_memory[icon_addr];
      display_on_o <= display_on;
      cursor_underline_o <= cursor_show & ~sel_glyph & (~cursor_char_blink | ~odd_phase);
      cursor_block_o <= cursor_char_blink & ~sel_glyph & ~odd_phase;
      cursor_addr_o <= addr_counter;
      disp_shift_o <= disp_shift;
      two_line_o <= two_line_sel;
      icon_only_o <= icon_only_sel;
      half_mirror_o <= half_mirror_sel & ~two_line_sel;
      column_mirror_o <= column_mirror;
      row_mirror_o <= row_mirror;
    end
  end

  // Parallel read drive, one cycle behind the strobe
  logic [7:0] rd_word;
  assign rd_word = reg_select_i ? read_latch : {busy_flag, addr_counter};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      db_oe_o <= 1'b0;
      db_o <= 8'h00;
    end else begin
      db_oe_o <= e_i & rw_i;
      if (bus_width_sel) begin
        db_o <= rd_word;
      end else begin
        db_o <= {nib ? rd_word[3:0] : rd_word[7:4], 4'hF};
      end
    end
  end

  // Wishbone slave, answers one cycle after the request, or two when a parallel transfer completes in that cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req & ~par_done;
      case (wb_adr_i)
        ADR_CMD: wb_dat_o <= {24'h000000, busy_flag, addr_counter};
        ADR_DATA: wb_dat_o <= {24'h000000, read_latch};
        ADR_CFG: wb_dat_o <= {18'h00000, bus_width_sel, two_line_sel, ext_set_sel, incr, entry_shift,
                              display_on, cursor_show, cursor_char_blink, icon_only_sel, icon_blink_en,
                              half_mirror_sel, column_mirror, row_mirror, sel_glyph};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  property p_busy_three;
    @(posedge clk_i) disable iff (rst_i) (go && !i_clear) |=> busy_flag [*3] ##1 !busy_flag;
  endproperty
  a_busy_three: assert property (p_busy_three) else $error("busy not held three cycles");

  property p_dctl;
    @(posedge clk_i) disable iff (rst_i) i_dctl |=> (display_on == $past(b[2])) && (cursor_show == $past(b[1]));
  endproperty
  a_dctl: assert property (p_dctl) else $error("display control not applied");

  property p_serial_width;
    @(posedge clk_i) disable iff (rst_i) (i_func && req_serial) |=> bus_width_sel;
  endproperty
  a_serial_width: assert property (p_serial_width) else $error("serial function set left width at 0");

  property p_glyph_bit6;
    @(posedge clk_i) disable iff (rst_i) i_sglyph |=> addr_counter == {$past(addr_counter[6]), $past(b[5:0])};
  endproperty
  a_glyph_bit6: assert property (p_glyph_bit6) else $error("glyph address disturbed bit 6");

  property p_latch_hold;
    @(posedge clk_i) disable iff (rst_i) (is_write || i_shift || i_clear || i_home) |=> $stable(read_latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("read latch changed");

  property p_disp_shift_ac;
    @(posedge clk_i) disable iff (rst_i) (i_shift && b[3]) |=> $stable(addr_counter);
  endproperty
  a_disp_shift_ac: assert property (p_disp_shift_ac) else $error("display shift moved counter");

  property p_text_step;
    @(posedge clk_i) disable iff (rst_i)
      (is_write && !sel_glyph && incr && addr_counter != LAST_L1 && addr_counter != LAST_L2
        && addr_counter != LAST_1L) |=> addr_counter == $past(addr_counter) + 7'h01;
  endproperty
  a_text_step: assert property (p_text_step) else $error("write did not step counter");

  property p_nibble_pair;
    @(posedge clk_i) disable iff (rst_i)
      (e_fall && !bus_width_sel && !nib) |-> !par_done ##1 (nib && hi_nib == $past(cap_db[7:4]));
  endproperty
  a_nibble_pair: assert property (p_nibble_pair) else $error("first nibble completed a transfer");

  property p_icon_cmd;
    @(posedge clk_i) disable iff (rst_i) x_icon |=> icon_blink_en == $past(b[1]) ##1 icon_only_o == $past(b[2], 2);
  endproperty
  a_icon_cmd: assert property (p_icon_cmd) else $error("icon control not applied");
endmodule

// [lic_host_model.sv]
/*
  Behavioural host microcontroller on the 4/8-bit parallel bus of the core.
  Assumes the bench resolves the shared data lines and feeds them back on bus_i.
*/
`timescale 1ns/1ps
module lic_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic rs_i,
  input wire logic rw_i,
  input wire logic four_bit_i,
  input wire logic slow_i,
  input wire logic [7:0] dat_i,
  input wire logic [7:0] bus_i,
  output logic e_o,
  output logic reg_select_o,
  output logic rw_o,
  output logic done_o,
  output logic [7:0] db_o,
  output logic [7:0] rdat_o
);
  int k;
  initial begin
    e_o = 1'b0;
    reg_select_o = 1'b0;
    rw_o = 1'b0;
    done_o = 1'b0;
    db_o = 8'hFF;
    rdat_o = 8'h00;
  end
  // One transfer per go pulse; strobe high 3 or 6 cycles, low 2
  always begin
    @(posedge clk_i);
    done_o <= 1'b0;
    if (go_i && !rst_i) begin
      for (k = 0; k < (four_bit_i ? 2 : 1); k++) begin
        e_o <= 1'b1;
        reg_select_o <= rs_i;
        rw_o <= rw_i;
        // Low lines float high through pull-ups in 4-bit use
        if (rw_i) begin
          db_o <= 8'hFF;
        end else if (!four_bit_i) begin
          db_o <= dat_i;
        end else begin
          db_o <= (k == 0) ? {dat_i[7:4], 4'hF} : {dat_i[3:0], 4'hF};
        end
        repeat (slow_i ? 6 : 3) @(posedge clk_i);
        if (!four_bit_i) begin
          rdat_o <= bus_i;
        end else if (k == 0) begin
          rdat_o[7:4] <= bus_i[7:4];
        end else begin
          rdat_o[3:0] <= bus_i[7:4];
        end
        e_o <= 1'b0;
        db_o <= 8'hFF;
        repeat (2) @(posedge clk_i);
      end
      done_o <= 1'b1;
    end
  end
endmodule

// [tb_top.sv]
/*
  Self-checking bench for the LCD instruction core: parallel host model plus
  Wishbone register tasks. Assumes the package offsets and a 50 MHz clock.
*/
`timescale 1ns/1ps
module tb_top
  import lic_pkg::*;
;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, db_oe_o;
  logic [7:0] wb_adr, db_o;
  logic [31:0] wb_dat, wb_dat_o, r;
  logic go, p_rs, p_rw, four_bit, slow, h_e, h_rs, h_rw, h_done;
  logic [7:0] p_dat, h_db, h_rdat, bus;
  logic display_on_o, cursor_underline_o, cursor_block_o, two_line_o, icon_only_o;
  logic [5:0] disp_shift_o;
  logic [4:0] icon_row_o;
  int hi, lo;
  logic half_mirror_o, column_mirror_o, row_mirror_o;
  logic [6:0] cursor_addr_o;
  int fail_count, total_checks;
  // Device drive wins, else host lines or pull-ups
  assign bus = db_oe_o ? db_o : h_db;
  lic_core #(.BLINK_HALF(8)) i_lic_core (.clk_i(clk_i), .rst_i(rst_i), .e_i(h_e), .reg_select_i(h_rs),
    .rw_i(h_rw), .db_i(bus), .db_o(db_o), .db_oe_o(db_oe_o), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .icon_idx_i(5'h00), .icon_row_o(icon_row_o), .display_on_o(display_on_o),
    .cursor_underline_o(cursor_underline_o), .cursor_block_o(cursor_block_o), .cursor_addr_o(cursor_addr_o),
    .disp_shift_o(disp_shift_o), .two_line_o(two_line_o), .icon_only_o(icon_only_o),
    .half_mirror_o(half_mirror_o),
    .column_mirror_o(column_mirror_o), .row_mirror_o(row_mirror_o));
  lic_host_model i_lic_host_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .rs_i(p_rs), .rw_i(p_rw),
    .four_bit_i(four_bit), .slow_i(slow), .dat_i(p_dat), .bus_i(bus), .e_o(h_e), .reg_select_o(h_rs),
    .rw_o(h_rw), .done_o(h_done), .db_o(h_db), .rdat_o(h_rdat));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Classic single cycle; idle edge at entry keeps cyc low between cycles
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    r = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic par(input logic rs, input logic rw, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    go <= 1'b1;
    p_rs <= rs;
    p_rw <= rw;
    p_dat <= d;
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (h_done !== 1'b1 && n < 100);
    if (n >= 100) begin
      fail_count++;
      print_verdict();
    end
  endtask
  // Poll busy until clear before the next instruction
  task automatic idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, ADR_CMD, 32'h0);
      n++;
    end while (r[7] !== 1'b0 && n < 300);
    if (n >= 300) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic pcmd(input logic [7:0] d);
    par(1'b0, 1'b0, d);
    idle();
  endtask
  task automatic pdat(input logic [7:0] d);
    par(1'b1, 1'b0, d);
    idle();
  endtask
  initial begin
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we, go, p_rs, p_rw, four_bit, slow} = 8'h00;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    p_dat = 8'h00;
    fail_count = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADR_CFG, 32'h0);
    chk(r, 32'h2400);
    pcmd(8'h0E);
    chk(32'(display_on_o), 32'h1);
    chk(32'(cursor_underline_o), 32'h1);
    // Any 16 cycles span one full blink period of the shortened divider
    pcmd(8'h0F);
    hi = 0;
    lo = 0;
    repeat (16) begin
      @(posedge clk_i);
      hi += cursor_block_o;
      lo += (cursor_block_o == cursor_underline_o);
    end
    chk(32'(hi), 32'h8);
    chk(32'(lo), 32'h10);
    pcmd(8'h0E);
    pcmd(8'hC5);
    pdat(8'h41);
    pdat(8'h42);
    pdat(8'h43);
    par(1'b0, 1'b1, 8'h00);
    chk(32'(h_rdat), 32'h48);
    pcmd(8'hC5);
    wb(1'b0, ADR_DATA, 32'h0);
    chk(r & 32'hFF, 32'h41);
    pdat(8'h55);
    wb(1'b0, ADR_DATA, 32'h0);
    chk(r & 32'hFF, 32'h41);
    par(1'b1, 1'b1, 8'h00);
    idle();
    chk(32'(h_rdat), 32'h41);
    wb(1'b0, ADR_DATA, 32'h0);
    chk(r & 32'hFF, 32'h43);
    pcmd(8'h14);
    chk(32'(cursor_addr_o), 32'h48);
    pcmd(8'h1C);
    chk(32'(cursor_addr_o), 32'h48);
    chk(32'(disp_shift_o), 32'h1);
    wb(1'b0, ADR_DATA, 32'h0);
    chk(r & 32'hFF, 32'h43);
    pcmd(8'h43);
    chk(32'(cursor_addr_o), 32'h43);
    pdat(8'hFF);
    pcmd(8'h43);
    par(1'b1, 1'b1, 8'h00);
    idle();
    chk(32'(h_rdat), 32'h1F);
    pcmd(8'h80);
    pcmd(8'h40);
    chk(32'(cursor_addr_o), 32'h00);
    pdat(8'hEA);
    chk(32'(icon_row_o), 32'h0A);
    pcmd(8'hC5);
    wb(1'b1, ADR_CMD, 32'h01);
    wb(1'b0, ADR_CMD, 32'h0);
    chk(r & 32'h80, 32'h80);
    idle();
    chk(32'(cursor_addr_o), 32'h00);
    wb(1'b1, ADR_CMD, 32'h24);
    idle();
    wb(1'b0, ADR_CFG, 32'h0);
    chk(r, 32'h3580);
    pcmd(8'h2F);
    four_bit <= 1'b1;
    wb(1'b0, ADR_CFG, 32'h0);
    chk(r, 32'h1D80);
    pcmd(8'h21);
    chk(32'(two_line_o), 32'h0);
    wb(1'b0, ADR_CFG, 32'h0);
    chk(r, 32'h0D80);
    pcmd(8'h0C);
    chk(32'(icon_only_o), 32'h1);
    pcmd(8'h03);
    chk(32'(half_mirror_o), 32'h1);
    pcmd(8'h06);
    chk(32'(column_mirror_o), 32'h1);
    chk(32'(row_mirror_o), 32'h0);
    slow <= 1'b1;
    pcmd(8'h20);
    pcmd(8'hC5);
    par(1'b0, 1'b1, 8'h00);
    chk(32'(h_rdat), 32'h45);
    slow <= 1'b0;
    pcmd(8'h30);
    four_bit <= 1'b0;
    par(1'b0, 1'b1, 8'h00);
    chk(32'(h_rdat), 32'h45);
    print_verdict();
  end
endmodule
